// *** core/epswc_top.sv ***
// Ethernet power-state and wake controller with Wishbone slave
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
module epswc_top #(
  parameter int PULSE_CYC  = epswc_pkg::EPSWC_PULSE_CYC,
  parameter int RESUME_CYC = epswc_pkg::EPSWC_RESUME_CYC
) (
  // Clock and reset
  input  wire logic                 CLK_SYS_IN,
  input  wire logic                 RST_B_IN,
  // Wishbone slave
  input  wire logic                 WB_CYC_IN,
  input  wire logic                 WB_STB_IN,
  input  wire logic                 WB_WE_IN,
  input  wire logic [7:0]           WB_ADR_IN,
  input  wire logic [3:0]           WB_SEL_IN,
  input  wire logic [31:0]          WB_DAT_IN,
  output logic      [31:0]          WB_DAT_OUT,
  output logic                      WB_ACK_OUT,
  output logic                      WB_ERR_OUT,
  // Wake detectors and line energy
  input  wire logic                 WAKE_FRAME_IN,
  input  wire logic                 LINE_ENERGY_IN,
  // Wake pin and interrupt status level
  output logic                      WAKE_PIN_OUT,
  output logic                      WAKE_INT_OUT,
  // Clock gating and PHY power controls
  output epswc_pkg::epswc_clk_type  CLK_CTRL_OUT,
  output logic                      PHY_POWERDOWN_OUT,
  output logic                      PHY_RESET_OUT
);
  // ===========================================================
  // Synchronisers
  logic [1:0] frame_sync_reg;
  logic [1:0] energy_sync_reg;
  logic       frame_prev_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      frame_sync_reg  <= 2'h0;
      energy_sync_reg <= 2'h0;
      frame_prev_reg  <= 1'b0;
    end else begin
      frame_sync_reg  <= {frame_sync_reg[0], WAKE_FRAME_IN};
      energy_sync_reg <= {energy_sync_reg[0], LINE_ENERGY_IN};
      frame_prev_reg  <= frame_sync_reg[1];
    end
  end
  logic frame_hit;
  logic energy_lvl;
  assign frame_hit  = frame_sync_reg[1] && !frame_prev_reg;
  assign energy_lvl = energy_sync_reg[1];

  // ===========================================================
  // Bus decode
  epswc_pkg::epswc_state_type state_reg;
  logic        ready_reg;
  logic        read_seen_reg;
  logic        pin_en_reg, pulse_sel_reg, wf_en_reg, energy_en_reg;
  logic [1:0]  wake_stat_reg;
  logic        wake_int_reg;
  logic        gpd_reg, edpd_reg, eflag_reg;
  logic        req, wr, rd, ack_reg, err_reg;
  logic        sleeping, wr_ok, wr_pmc, wr_test, wr_int, wr_phy, mapped, legal;
  assign req      = WB_CYC_IN && WB_STB_IN && !ack_reg && !err_reg;
  assign sleeping = (state_reg != epswc_pkg::EPSWC_D0);
  assign mapped   = (WB_ADR_IN <= epswc_pkg::EPSWC_ADDR_PHYSTS);
  // While asleep only the control read and the wake write are served
  assign legal    = !sleeping || (WB_WE_IN ? (WB_ADR_IN == epswc_pkg::EPSWC_ADDR_WAKETEST)
                                           : (WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PMC));
  assign wr       = req && WB_WE_IN && mapped && legal;
  assign rd       = req && !WB_WE_IN && mapped && legal;
  assign wr_ok    = wr && read_seen_reg && ready_reg;
  assign wr_pmc   = wr_ok && WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PMC;
  assign wr_int   = wr_ok && WB_ADR_IN == epswc_pkg::EPSWC_ADDR_INTSTS;
  assign wr_phy   = wr_ok && WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PHYCTL;
  // Wake write skips the read lock, else a locked sleeper could never wake
  assign wr_test  = wr && WB_ADR_IN == epswc_pkg::EPSWC_ADDR_WAKETEST;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req && mapped && legal;
      err_reg <= req && !(mapped && legal);
    end
  end
  assign WB_ACK_OUT = ack_reg;
  assign WB_ERR_OUT = err_reg;

  // Any read while ready arms writes again after reset or wake
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      read_seen_reg <= 1'b0;
    end else if (wr_test && sleeping) begin
      read_seen_reg <= 1'b0;
    end else if (rd && ready_reg) begin
      read_seen_reg <= 1'b1;
    end
  end

  // ===========================================================
  // Power state machine
  logic [1:0]  mode_wr;
  logic [15:0] resume_cnt_reg;
  assign mode_wr = WB_DAT_IN[epswc_pkg::EPSWC_PMC_MODE_LO +: 2];
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      state_reg      <= epswc_pkg::EPSWC_D0;
      ready_reg      <= 1'b1;
      resume_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        epswc_pkg::EPSWC_D0: begin
          if (wr_pmc && WB_SEL_IN[2] && mode_wr == 2'h1) begin
            state_reg <= epswc_pkg::EPSWC_D1;
            ready_reg <= 1'b0;
          end else if (wr_pmc && WB_SEL_IN[2] && mode_wr == 2'h2) begin
            state_reg <= epswc_pkg::EPSWC_D2;
            ready_reg <= 1'b0;
          end
        end
        epswc_pkg::EPSWC_D1, epswc_pkg::EPSWC_D2: begin
          if (wr_test) begin
            state_reg      <= epswc_pkg::EPSWC_WAKING;
            resume_cnt_reg <= 16'h0000;
          end
        end
        epswc_pkg::EPSWC_WAKING: begin
          // Clocks restart first, ready follows the restart delay
          if (resume_cnt_reg == 16'(RESUME_CYC - 1)) begin
            state_reg <= epswc_pkg::EPSWC_D0;
            ready_reg <= 1'b1;
          end else begin
            resume_cnt_reg <= resume_cnt_reg + 16'h0001;
          end
        end
        default: state_reg <= epswc_pkg::EPSWC_D0;
      endcase
    end
  end
  logic [1:0] mode_rd;
  assign mode_rd = (state_reg == epswc_pkg::EPSWC_D1) ? 2'h1 :
                   (state_reg == epswc_pkg::EPSWC_D2) ? 2'h2 : 2'h0;

  // Clock gating per state
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      CLK_CTRL_OUT <= '{mac_clk_en: 1'b1, host_clk_en: 1'b1, int_clk_en: 1'b1, rxpm_en: 1'b1, phy_on: 1'b1};
    end else begin
      CLK_CTRL_OUT.mac_clk_en  <= !(state_reg == epswc_pkg::EPSWC_D1 || state_reg == epswc_pkg::EPSWC_D2);
      CLK_CTRL_OUT.host_clk_en <= !(state_reg == epswc_pkg::EPSWC_D1 || state_reg == epswc_pkg::EPSWC_D2);
      CLK_CTRL_OUT.int_clk_en  <= state_reg != epswc_pkg::EPSWC_D2;
      CLK_CTRL_OUT.rxpm_en     <= state_reg != epswc_pkg::EPSWC_D2;
      CLK_CTRL_OUT.phy_on      <= !gpd_reg && !(edpd_reg && !energy_lvl);
    end
  end

  // ===========================================================
  // Control bits, kept through sleep
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      pin_en_reg    <= 1'b0;
      pulse_sel_reg <= 1'b0;
      wf_en_reg     <= 1'b0;
      energy_en_reg <= 1'b0;
    end else if (wr_pmc && WB_SEL_IN[0]) begin
      pin_en_reg    <= WB_DAT_IN[epswc_pkg::EPSWC_PMC_PINEN];
      pulse_sel_reg <= WB_DAT_IN[epswc_pkg::EPSWC_PMC_PULSE];
    end
    if (RST_B_IN && wr_pmc && WB_SEL_IN[1]) begin
      wf_en_reg     <= WB_DAT_IN[epswc_pkg::EPSWC_PMC_WFEN];
      energy_en_reg <= WB_DAT_IN[epswc_pkg::EPSWC_PMC_EDEN];
    end
  end

  // Wake detection; set beats a software clear
  logic set_frame, set_energy;
  assign set_frame  = state_reg == epswc_pkg::EPSWC_D1 && frame_hit;
  assign set_energy = state_reg == epswc_pkg::EPSWC_D2 && energy_lvl;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      wake_stat_reg <= epswc_pkg::EPSWC_WST_NONE;
    end else if (set_frame) begin
      wake_stat_reg <= epswc_pkg::EPSWC_WST_FRAME;
    end else if (set_energy) begin
      wake_stat_reg <= epswc_pkg::EPSWC_WST_ENERGY;
    end else if (wr_pmc && WB_SEL_IN[1]) begin
      wake_stat_reg <= wake_stat_reg & ~WB_DAT_IN[epswc_pkg::EPSWC_PMC_WST_LO +: 2];
    end
  end

  logic wake_active;
  assign wake_active = (wake_stat_reg == epswc_pkg::EPSWC_WST_FRAME && wf_en_reg) ||
                       (wake_stat_reg == epswc_pkg::EPSWC_WST_ENERGY && energy_en_reg);
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      wake_int_reg <= 1'b0;
    end else if (wake_active) begin
      wake_int_reg <= 1'b1;
    end else if (wr_int && WB_SEL_IN[2] && WB_DAT_IN[epswc_pkg::EPSWC_INT_WAKE]) begin
      wake_int_reg <= 1'b0;
    end
  end
  assign WAKE_INT_OUT = wake_int_reg;

  // ===========================================================
  // Wake pin, pulsed or static
  logic [21:0] pulse_cnt_reg;
  logic        wake_prev_reg;
  logic        pin_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      pin_reg       <= 1'b0;
      pulse_cnt_reg <= 22'h000000;
      wake_prev_reg <= 1'b0;
    end else begin
      wake_prev_reg <= wake_active;
      if (!wake_active || !pin_en_reg) begin
        pin_reg <= 1'b0;
      end else if (!wake_prev_reg) begin
        pin_reg       <= 1'b1;
        pulse_cnt_reg <= 22'h000000;
      end else if (pulse_sel_reg && pin_reg) begin
        if (pulse_cnt_reg == 22'(PULSE_CYC - 1)) begin
          pin_reg <= 1'b0;
        end else begin
          pulse_cnt_reg <= pulse_cnt_reg + 22'h000001;
        end
      end
    end
  end
  assign WAKE_PIN_OUT = pin_reg;

  // ===========================================================
  // PHY power bits
  logic [4:0] phy_rst_cnt_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      gpd_reg   <= 1'b0;
      edpd_reg  <= 1'b0;
      eflag_reg <= 1'b0;
    end else begin
      if (wr_phy && WB_SEL_IN[0]) begin
        gpd_reg  <= WB_DAT_IN[epswc_pkg::EPSWC_PHY_GPD];
        edpd_reg <= WB_DAT_IN[epswc_pkg::EPSWC_PHY_EDPD];
      end
      if (edpd_reg && energy_lvl && !CLK_CTRL_OUT.phy_on) begin
        eflag_reg <= 1'b1;
      end else if (rd && WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PHYSTS) begin
        eflag_reg <= 1'b0;
      end
    end
  end
  // Clearing general powerdown resets the PHY for a short while
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      phy_rst_cnt_reg <= 5'h00;
    end else if (wr_phy && WB_SEL_IN[0] && gpd_reg && !WB_DAT_IN[epswc_pkg::EPSWC_PHY_GPD]) begin
      phy_rst_cnt_reg <= 5'(epswc_pkg::EPSWC_PHYRST_CYC);
    end else if (phy_rst_cnt_reg != 5'h00) begin
      phy_rst_cnt_reg <= phy_rst_cnt_reg - 5'h01;
    end
  end
  assign PHY_RESET_OUT     = phy_rst_cnt_reg != 5'h00;
  // Limitation: first packets after energy wake may be lost upstream
  assign PHY_POWERDOWN_OUT = gpd_reg || (edpd_reg && !energy_lvl);

  // ===========================================================
  // Read data
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      WB_DAT_OUT <= 32'h00000000;
    end else if (rd) begin
      WB_DAT_OUT <= 32'h00000000;
      if (WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PMC) begin
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_READY]         <= ready_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_PINEN]         <= pin_en_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_PULSE]         <= pulse_sel_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_WFEN]          <= wf_en_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_EDEN]          <= energy_en_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_WST_LO +: 2]   <= wake_stat_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PMC_MODE_LO +: 2]  <= mode_rd;
      end else if (WB_ADR_IN == epswc_pkg::EPSWC_ADDR_INTSTS) begin
        WB_DAT_OUT[epswc_pkg::EPSWC_INT_WAKE] <= wake_int_reg;
      end else if (WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PHYCTL) begin
        WB_DAT_OUT[epswc_pkg::EPSWC_PHY_GPD]  <= gpd_reg;
        WB_DAT_OUT[epswc_pkg::EPSWC_PHY_EDPD] <= edpd_reg;
      end else if (WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PHYSTS) begin
        WB_DAT_OUT[epswc_pkg::EPSWC_PHY_EFLAG] <= eflag_reg;
      end
    end
  end

  // ===========================================================
  // Assertions
  a_d1_entry_ready: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state_reg == epswc_pkg::EPSWC_D0 && wr_pmc && WB_SEL_IN[2] && mode_wr == 2'h1)
    |=> (state_reg == epswc_pkg::EPSWC_D1 && !ready_reg)) else $error("D1 entry wrong");
  a_d2_entry_ready: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state_reg == epswc_pkg::EPSWC_D0 && wr_pmc && WB_SEL_IN[2] && mode_wr == 2'h2)
    |=> (state_reg == epswc_pkg::EPSWC_D2 && !ready_reg)) else $error("D2 entry wrong");
  a_wake_write_d0: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (sleeping && state_reg != epswc_pkg::EPSWC_WAKING && wr_test)
    |=> state_reg == epswc_pkg::EPSWC_WAKING ##[1:200] ready_reg) else $error("Wake write ignored");
  a_sleep_no_ready: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    sleeping |-> !ready_reg) else $error("Ready high while asleep");
  a_ready_after_clk: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    $rose(ready_reg) |-> CLK_CTRL_OUT.mac_clk_en && CLK_CTRL_OUT.host_clk_en) else $error("Ready before clocks");
  a_frame_status: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    set_frame |=> wake_stat_reg == epswc_pkg::EPSWC_WST_FRAME) else $error("Frame status not set");
  a_energy_status: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (set_energy && !set_frame) |=> wake_stat_reg == epswc_pkg::EPSWC_WST_ENERGY) else $error("Energy status not set");
  a_pin_gate: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (!pin_en_reg || !wake_active) |=> !pin_reg) else $error("Pin not released");
  a_int_holds: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    wake_active |=> wake_int_reg) else $error("Wake int dropped while active");
  a_pin_rise: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    $rose(pin_reg) |-> $past(pin_en_reg) && $past(wake_active)) else $error("Pin rose without enable");
  a_d1_clocks: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    state_reg == epswc_pkg::EPSWC_D1 |=> !CLK_CTRL_OUT.mac_clk_en && CLK_CTRL_OUT.int_clk_en)
    else $error("D1 clock gating wrong");
  a_write_locked: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr && !read_seen_reg && WB_ADR_IN == epswc_pkg::EPSWC_ADDR_PHYCTL) |=> $stable(gpd_reg))
    else $error("Write before first read");
  a_d2_clocks: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    state_reg == epswc_pkg::EPSWC_D2 |=> !CLK_CTRL_OUT.int_clk_en && !CLK_CTRL_OUT.host_clk_en)
    else $error("D2 clock gating wrong");
  a_pin_static: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (pin_reg && !pulse_sel_reg && wake_active && pin_en_reg) |=> pin_reg) else $error("Static pin dropped");
  a_sleep_refuse: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (req && sleeping && !WB_WE_IN && WB_ADR_IN != epswc_pkg::EPSWC_ADDR_PMC) |=> WB_ERR_OUT)
    else $error("Sleep read not refused");
  a_energy_flag: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (edpd_reg && energy_lvl && !CLK_CTRL_OUT.phy_on) |=> eflag_reg) else $error("Energy flag not set");
  a_phy_reset: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr_phy && WB_SEL_IN[0] && gpd_reg && !WB_DAT_IN[epswc_pkg::EPSWC_PHY_GPD]) |=> PHY_RESET_OUT)
    else $error("PHY reset missing");
  // Covers: the main sleep, wake and PHY paths
  c_d1_wake: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) set_frame ##[1:50] wr_test);
  c_d2_pin: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) set_energy && pin_en_reg);
  c_pulse_end: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) $fell(pin_reg) && wake_active);
  c_d1_quiet: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) set_frame && !pin_en_reg);
  c_phy_reset: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) $fell(PHY_RESET_OUT));
endmodule : epswc_top

// *** core/epswc_pkg.sv ***
// Package for the Ethernet power-state and wake controller
package epswc_pkg;
  // ===========================================================
  // Register map (word addresses, byte address = index * 4)
  localparam logic [7:0] EPSWC_ADDR_PMC      = 8'h00;  // power_mgmt_control
  localparam logic [7:0] EPSWC_ADDR_WAKETEST = 8'h01;  // wake test register
  localparam logic [7:0] EPSWC_ADDR_INTSTS   = 8'h02;  // interrupt_status_register
  localparam logic [7:0] EPSWC_ADDR_PHYCTL   = 8'h03;  // PHY power control bits
  localparam logic [7:0] EPSWC_ADDR_PHYSTS   = 8'h04;  // PHY status
  // ===========================================================
  // power_mgmt_control, interrupt status and PHY register fields
  localparam int EPSWC_PMC_READY   = 0;
  localparam int EPSWC_PMC_PINEN   = 1;
  localparam int EPSWC_PMC_PULSE   = 3;
  localparam int EPSWC_PMC_WFEN    = 9;
  localparam int EPSWC_PMC_EDEN    = 14;
  localparam int EPSWC_PMC_WST_LO  = 12;
  localparam int EPSWC_PMC_MODE_LO = 16;
  localparam int EPSWC_INT_WAKE    = 17;
  localparam int EPSWC_PHY_GPD     = 0;
  localparam int EPSWC_PHY_EDPD    = 1;
  localparam int EPSWC_PHY_EFLAG   = 2;
  localparam logic [1:0] EPSWC_WST_NONE    = 2'h0;
  localparam logic [1:0] EPSWC_WST_ENERGY  = 2'h1;
  localparam logic [1:0] EPSWC_WST_FRAME   = 2'h2;
  // ===========================================================
  // Timing
  localparam int EPSWC_CLK_MHZ        = 50;
  localparam int EPSWC_PULSE_MS       = 50;
  localparam int EPSWC_PULSE_CYC      = EPSWC_PULSE_MS * 1000 * EPSWC_CLK_MHZ;
  localparam int EPSWC_RESUME_US      = 2;
  localparam int EPSWC_RESUME_CYC     = EPSWC_RESUME_US * EPSWC_CLK_MHZ;
  localparam int EPSWC_PHYRST_CYC     = 16;
  typedef enum logic [1:0] {EPSWC_D0, EPSWC_D1, EPSWC_D2, EPSWC_WAKING} epswc_state_type;
  typedef struct packed {
    logic mac_clk_en;
    logic host_clk_en;
    logic int_clk_en;
    logic rxpm_en;
    logic phy_on;
  } epswc_clk_type;
endpackage : epswc_pkg

// *** tb/epswc_host_model.sv ***
// Host CPU model: Wishbone classic master for the power controller
`timescale 1ns/1ps
module epswc_host_model (
  // Clock
  input  wire logic        clk_in,
  // Wishbone master side
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic [7:0]       adr_out,
  output logic [3:0]       sel_out,
  output logic [31:0]      dat_out,
  input  wire logic [31:0] dat_in,
  input  wire logic        ack_in,
  input  wire logic        err_in
);
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out  = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'h0;
    dat_out = 32'h0000_0000;
  end
  // ==========================================
  // One classic cycle, held until ack or err is sampled
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out  <= we;
    adr_out <= adr;
    sel_out <= 4'hF;
    dat_out <= dat;
    @(posedge clk_in);
    while (ack_in !== 1'b1 && err_in !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    // Released lines show garbage so no stale value can pass
    adr_out <= ~adr;
    dat_out <= ~dat;
  endtask : xfer
endmodule : epswc_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the power-state and wake controller
`timescale 1ns/1ps
module tb_top;
  localparam int         PULSE  = 20;
  localparam int         RESUME = 10;
  localparam logic [7:0] A_PMC  = epswc_pkg::EPSWC_ADDR_PMC;
  localparam logic [7:0] A_WAKE = epswc_pkg::EPSWC_ADDR_WAKETEST;
  localparam logic [7:0] A_INT  = epswc_pkg::EPSWC_ADDR_INTSTS;
  localparam logic [7:0] A_PHY  = epswc_pkg::EPSWC_ADDR_PHYCTL;
  localparam logic [7:0] A_STS  = epswc_pkg::EPSWC_ADDR_PHYSTS;
  logic clk = 1'b0;
  logic rst_b, cyc, stb, we, ack, err, wake_frame, energy, pin, wint, pd, prst;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, rdata, rnd;
  logic [64:0] note;
  logic [64:0] notes[$];
  epswc_pkg::epswc_clk_type clks;
  int fail_count = 0;
  int compares = 0;
  always #10 clk = ~clk;
  epswc_top #(.PULSE_CYC(PULSE), .RESUME_CYC(RESUME)) i_epswc_top (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack),
    .WB_ERR_OUT(err), .WAKE_FRAME_IN(wake_frame), .LINE_ENERGY_IN(energy), .WAKE_PIN_OUT(pin),
    .WAKE_INT_OUT(wint), .CLK_CTRL_OUT(clks), .PHY_POWERDOWN_OUT(pd), .PHY_RESET_OUT(prst));
  epswc_host_model i_epswc_host_model (
    .clk_in(clk), .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel),
    .dat_out(dat_w), .dat_in(dat_r), .ack_in(ack), .err_in(err));
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic sig(input int w);
    case (w)
      0: return pin;
      1: return prst;
      2: return pd;
      default: return wint;
    endcase
  endfunction : sig
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Expectation goes on the queue before the request is raised
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] v, input logic e);
    notes.push_back({e, m, v});
    i_epswc_host_model.xfer(w, a, d, rdata);
  endtask : bus
  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (sig(w) !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'(sig(w)), 32'(v));
  endtask : wait_for
  task automatic measure(input int w, input int exp);
    int n;
    n = 0;
    while (sig(w) === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(exp));
  endtask : measure
  task automatic wake;
    int n;
    rnd = lfsr_next(rnd);
    bus(1'b1, A_WAKE, rnd, 32'h0, 32'h0, 1'b0);
    bus(1'b0, A_PMC, rnd, 32'h0000_0001, 32'h0, 1'b0);
    n = 0;
    while (rdata[0] !== 1'b1 && n < 40) begin
      bus(1'b0, A_PMC, rnd, 32'h0, 32'h0, 1'b0);
      n++;
    end
    chk(32'(rdata[0]), 32'h1);
    bus(1'b0, A_PMC, rnd, 32'h0003_0000, 32'h0, 1'b0);
    chk(32'(clks), 32'h0000_001F);
  endtask : wake
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Result watcher: oldest note against each ack or err
  always @(posedge clk) begin
    if (ack === 1'b1 || err === 1'b1) begin
      if (notes.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        note = notes.pop_front();
        chk(32'(err), 32'(note[64]));
        chk(dat_r & note[63:32], note[31:0] & note[63:32]);
      end
    end
  end
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    wake_frame = 1'b0;
    energy = 1'b0;
    rnd = 32'h0000_12A6;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b1, A_PMC, 32'h0000_0002, 32'h0, 32'h0, 1'b0);
    bus(1'b1, A_PHY, 32'h0000_0001, 32'h0, 32'h0, 1'b0);
    chk(32'(pd), 32'h0);
    bus(1'b0, A_PMC, rnd, 32'h0003_0003, 32'h0000_0001, 1'b0);
    bus(1'b1, A_PMC, 32'h0000_0002, 32'h0, 32'h0, 1'b0);
    bus(1'b0, A_PMC, rnd, 32'h0000_0002, 32'h0000_0002, 1'b0);
    bus(1'b0, 8'h05, rnd, 32'h0, 32'h0, 1'b1);
    $display("test reset_gate done");
    bus(1'b1, A_PMC, 32'h0001_0202, 32'h0, 32'h0, 1'b0);
    bus(1'b0, A_PMC, rnd, 32'h0003_0001, 32'h0001_0000, 1'b0);
    bus(1'b0, A_INT, rnd, 32'h0, 32'h0, 1'b1);
    bus(1'b1, A_PHY, 32'h0000_0001, 32'h0, 32'h0, 1'b1);
    chk(32'(clks), 32'h0000_0007);
    wake_frame <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(3, 1'b1);
    bus(1'b0, A_PMC, rnd, 32'h0000_3000, 32'h0000_2000, 1'b0);
    wake();
    bus(1'b0, A_PMC, rnd, 32'h0000_0202, 32'h0000_0202, 1'b0);
    wait_for(0, 1'b1);
    bus(1'b1, A_INT, 32'h0002_0000, 32'h0, 32'h0, 1'b0);
    @(posedge clk);
    chk(32'(wint), 32'h1);
    bus(1'b1, A_PMC, 32'h0000_3202, 32'h0, 32'h0, 1'b0);
    wait_for(0, 1'b0);
    wake_frame <= 1'b0;
    bus(1'b1, A_INT, 32'h0002_0000, 32'h0, 32'h0, 1'b0);
    wait_for(3, 1'b0);
    $display("test d1_sleep done");
    energy <= 1'b1;
    bus(1'b1, A_PHY, 32'h0000_0002, 32'h0, 32'h0, 1'b0);
    bus(1'b1, A_PMC, 32'h0002_400A, 32'h0, 32'h0, 1'b0);
    wait_for(0, 1'b1);
    measure(0, PULSE);
    chk(32'({clks.mac_clk_en, clks.host_clk_en, clks.int_clk_en}), 32'h0);
    wait_for(3, 1'b1);
    bus(1'b0, A_PMC, rnd, 32'h0003_3001, 32'h0002_1000, 1'b0);
    energy <= 1'b0;
    wait_for(2, 1'b1);
    energy <= 1'b1;
    wait_for(2, 1'b0);
    wake();
    bus(1'b1, A_PHY, 32'h0, 32'h0, 32'h0, 1'b0);
    bus(1'b0, A_STS, rnd, 32'h0000_0004, 32'h0000_0004, 1'b0);
    $display("test d2_sleep done");
    bus(1'b1, A_PHY, 32'h0000_0001, 32'h0, 32'h0, 1'b0);
    wait_for(2, 1'b1);
    bus(1'b1, A_PHY, 32'h0, 32'h0, 32'h0, 1'b0);
    wait_for(1, 1'b1);
    measure(1, epswc_pkg::EPSWC_PHYRST_CYC);
    $display("test phy_powerdown done");
    bus(1'b1, A_PMC, 32'h0000_3000, 32'h0, 32'h0, 1'b0);
    bus(1'b1, A_INT, 32'h0002_0000, 32'h0, 32'h0, 1'b0);
    chk(32'(wint), 32'h0);
    bus(1'b1, A_PMC, 32'h0001_0200, 32'h0, 32'h0, 1'b0);
    wake_frame <= 1'b1;
    wait_for(3, 1'b1);
    chk(32'(pin), 32'h0);
    wake();
    $display("test d1_no_pin done");
    tally_and_finish();
  end
endmodule : tb_top
